//--- hw/shp_cfg.svh
// Purpose: constants of the serial host port: offsets, fields, resets, counts
// Assumes: 32-bit APB data, one register per aligned word
// Notes: definitions only
`ifndef SHP_CFG_SVH
`define SHP_CFG_SVH

// ==========================================================================
// register map
`define SHP_ADDR_CTRL 12'h000
`define SHP_ADDR_STATUS 12'h004
`define SHP_ADDR_TXDATA 12'h008
`define SHP_ADDR_RXDATA 12'h00C

// ==========================================================================
// control fields and reset values
`define SHP_CTRL_BAUD_LSB 0
`define SHP_CTRL_FMT_LSB 3
`define SHP_BAUD_SEL_RST 3'h5
`define SHP_BAUD_SEL_MAX 3'h5
`define SHP_FMT_NONE8 2'h0
`define SHP_FMT_EVEN7 2'h1
`define SHP_FMT_ODD7 2'h2

// ==========================================================================
// status bit positions
`define SHP_ST_RX_FULL 0
`define SHP_ST_PAR_ERR 1
`define SHP_ST_FRM_ERR 2
`define SHP_ST_OVERRUN 3
`define SHP_ST_TX_READY 4
`define SHP_ST_TX_BUSY 5
`define SHP_ST_DSR 6
`define SHP_ST_DTR 7
`define SHP_ST_TX_CNT_LSB 8

// ==========================================================================
// line rates and framing
`define SHP_CLK_HZ 40000000
`define SHP_BAUD_0 300
`define SHP_BAUD_1 600
`define SHP_BAUD_2 1200
`define SHP_BAUD_3 2400
`define SHP_BAUD_4 4800
`define SHP_BAUD_5 9600
`define SHP_OVERSAMPLE 16
`define SHP_TICK_LAST 4'hF
`define SHP_TICK_MID 4'h7
`define SHP_DATA_LAST_8 3'h7
`define SHP_DATA_LAST_7 3'h6
`define SHP_STOP_LAST 3'h1
`define SHP_FIFO_DEPTH 4
`define SHP_CHAR_W 8

`endif

//--- hw/shp_pkg.sv
// Purpose: shared types of the serial host port
// Assumes: nothing
// Notes: constants live in shp_cfg.svh
package shp_pkg;

    typedef enum logic [2:0] {
        LINE_IDLE = 3'h0,
        LINE_START = 3'h1,
        LINE_DATA = 3'h2,
        LINE_PARITY = 3'h3,
        LINE_STOP = 3'h4
    } line_state_e;

    typedef struct packed {
        logic [1:0] fmt;
        logic [2:0] baud_sel;
    } ctrl_s;

    typedef struct packed {
        logic overrun;
        logic frame;
        logic parity;
    } err_s;

    typedef struct packed {
        line_state_e st;
        logic [3:0] tick;
        logic [2:0] bit_n;
        logic [7:0] sh;
        logic par;
        logic txd;
    } tx_s;

    typedef struct packed {
        line_state_e st;
        logic [3:0] tick;
        logic [2:0] bit_n;
        logic [7:0] sh;
        logic [7:0] hold;
        logic full;
    } rx_s;

endpackage : shp_pkg

//--- hw/shp_fifo.sv
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: in_ready low when full, out_valid low when empty
`timescale 1ns/100ps
module shp_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] count
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign count = cnt_q;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = in_data;
            wr_d = AW'(wr_q + 1'b1);
        end
        if (pop) begin
            rd_d = AW'(rd_q + 1'b1);
        end
        if (push && !pop) begin
            cnt_d = (AW+1)'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = (AW+1)'(cnt_q - 1'b1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

endmodule : shp_fifo

//--- hw/shp_baud_tick.sv
// Purpose: oversampling tick, one pulse every div clocks
// Assumes: div of at least 1
// Notes: a smaller new div takes effect at once
`timescale 1ns/100ps
module shp_baud_tick (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [13:0] div,
    output logic tick
);
    logic [13:0] cnt_q, cnt_d;
    logic tick_q, tick_d;

    assign tick = tick_q;

    always_comb begin
        cnt_d = 14'(cnt_q + 1'b1);
        tick_d = 1'b0;
        // >= rather than == so a reprogrammed divider never runs away
        if (cnt_q >= 14'(div - 1'b1)) begin
            cnt_d = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

endmodule : shp_baud_tick

//--- hw/shp_serial_host_port.sv
// Purpose: asynchronous serial port to a host, with APB registers
// Assumes: rxd and dsr synchronous to pclk; host uses the same framing
// Notes: 16x oversampling; four-character transmit FIFO
// Functional notes
// - rates 300 to 9600 baud, 9600 default
// - formats none/8, even/7, odd/7; none/8 default
// - exactly one start bit per frame
// - exactly two stop bits per frame
// - start, data, optional parity, two stops
// - terminal role, paced by dtr and dsr
`timescale 1ns/100ps
`include "shp_cfg.svh"
module shp_serial_host_port #(
    parameter int unsigned CLK_HZ = `SHP_CLK_HZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    output logic txd,
    input wire logic dsr,
    output logic dtr
);

    // ======================================================================
    // divider per rate selection
    function automatic logic [13:0] baud_div(input logic [2:0] sel);
        int unsigned rate;
        int unsigned q;
        unique case (sel)
            3'h0: rate = `SHP_BAUD_0;
            3'h1: rate = `SHP_BAUD_1;
            3'h2: rate = `SHP_BAUD_2;
            3'h3: rate = `SHP_BAUD_3;
            3'h4: rate = `SHP_BAUD_4;
            default: rate = `SHP_BAUD_5;
        endcase
        q = CLK_HZ / (`SHP_OVERSAMPLE * rate);
        // never below one clock per tick
        baud_div = (q == 0) ? 14'h0001 : 14'(q);
    endfunction : baud_div

    // ======================================================================
    // declarations
    shp_pkg::ctrl_s ctrl_q, ctrl_d;
    shp_pkg::err_s err_q, err_d, err_set, err_clr;
    shp_pkg::tx_s tx_q, tx_d;
    shp_pkg::rx_s rx_q, rx_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic dtr_q, dtr_d;
    logic setup, access, mapped;
    logic wr_ctrl, wr_status, wr_tx, rd_rx;
    logic tick;
    logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [7:0] fifo_out_data;
    logic [$clog2(`SHP_FIFO_DEPTH):0] fifo_count;
    logic parity_on, odd_sel;
    logic [2:0] data_last;
    logic tx_bit_end, rx_sample;
    logic [7:0] rx_char;
    logic [31:0] status_w;

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign txd = tx_q.txd;
    assign dtr = dtr_q;

    // ======================================================================
    // format decode
    assign parity_on = (ctrl_q.fmt != `SHP_FMT_NONE8);
    assign odd_sel = (ctrl_q.fmt == `SHP_FMT_ODD7);
    assign data_last = parity_on ? `SHP_DATA_LAST_7 : `SHP_DATA_LAST_8;

    // ======================================================================
    // rate generator and transmit buffer
    shp_baud_tick u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .div(baud_div(ctrl_q.baud_sel)),
        .tick(tick)
    );

    shp_fifo #(
        .WIDTH(`SHP_CHAR_W),
        .DEPTH(`SHP_FIFO_DEPTH)
    ) u_tx_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(wr_tx),
        .in_ready(fifo_in_ready),
        .in_data(pwdata[7:0]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .count(fifo_count)
    );

    // ======================================================================
    // apb decode
    assign setup = psel && !penable;
    assign access = psel && penable && pready_q;
    assign mapped = (paddr == `SHP_ADDR_CTRL) || (paddr == `SHP_ADDR_STATUS) ||
                    (paddr == `SHP_ADDR_TXDATA) || (paddr == `SHP_ADDR_RXDATA);
    assign wr_ctrl = access && pwrite && (paddr == `SHP_ADDR_CTRL);
    assign wr_status = access && pwrite && (paddr == `SHP_ADDR_STATUS);
    assign wr_tx = access && pwrite && (paddr == `SHP_ADDR_TXDATA);
    assign rd_rx = access && !pwrite && (paddr == `SHP_ADDR_RXDATA);

    always_comb begin
        status_w = '0;
        status_w[`SHP_ST_RX_FULL] = rx_q.full;
        status_w[`SHP_ST_PAR_ERR] = err_q.parity;
        status_w[`SHP_ST_FRM_ERR] = err_q.frame;
        status_w[`SHP_ST_OVERRUN] = err_q.overrun;
        status_w[`SHP_ST_TX_READY] = fifo_in_ready;
        status_w[`SHP_ST_TX_BUSY] = fifo_out_valid || (tx_q.st != shp_pkg::LINE_IDLE);
        status_w[`SHP_ST_DSR] = dsr;
        status_w[`SHP_ST_DTR] = dtr_q;
        status_w[`SHP_ST_TX_CNT_LSB +: 3] = fifo_count;
    end

    // ======================================================================
    // apb answer: one wait-free access phase after every setup
    always_comb begin
        pready_d = setup;
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        if (setup) begin
            prdata_d = '0;
            pslverr_d = !mapped || (pwrite && (paddr == `SHP_ADDR_TXDATA) && !fifo_in_ready);
            if (!pwrite) begin
                unique case (paddr)
                    `SHP_ADDR_CTRL: prdata_d = {27'h000_0000, ctrl_q};
                    `SHP_ADDR_STATUS: prdata_d = status_w;
                    `SHP_ADDR_RXDATA: prdata_d = {24'h00_0000, rx_q.hold};
                    default: prdata_d = '0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ======================================================================
    // control and sticky errors
    always_comb begin
        ctrl_d = ctrl_q;
        // unsupported codes leave the field as it was
        if (wr_ctrl && pwdata[`SHP_CTRL_BAUD_LSB +: 3] <= `SHP_BAUD_SEL_MAX) begin
            ctrl_d.baud_sel = pwdata[`SHP_CTRL_BAUD_LSB +: 3];
        end
        if (wr_ctrl && pwdata[`SHP_CTRL_FMT_LSB +: 2] != 2'h3) begin
            ctrl_d.fmt = pwdata[`SHP_CTRL_FMT_LSB +: 2];
        end
        err_clr = '0;
        if (wr_status) begin
            err_clr.parity = pwdata[`SHP_ST_PAR_ERR];
            err_clr.frame = pwdata[`SHP_ST_FRM_ERR];
            err_clr.overrun = pwdata[`SHP_ST_OVERRUN];
        end
        // a new error in the clearing cycle is kept
        err_d = (err_q & ~err_clr) | err_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= '{fmt: `SHP_FMT_NONE8, baud_sel: `SHP_BAUD_SEL_RST};
            err_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            err_q <= err_d;
        end
    end

    // ======================================================================
    // transmitter
    assign tx_bit_end = tick && (tx_q.tick == `SHP_TICK_LAST);
    assign fifo_out_ready = (tx_q.st == shp_pkg::LINE_IDLE) && dsr;

    always_comb begin
        tx_d = tx_q;
        if (tick) begin
            tx_d.tick = 4'(tx_q.tick + 1'b1);
        end
        unique case (tx_q.st)
            shp_pkg::LINE_IDLE: begin
                tx_d.txd = 1'b1;
                if (fifo_out_valid && dsr) begin
                    tx_d.st = shp_pkg::LINE_START;
                    tx_d.tick = '0;
                    tx_d.sh = fifo_out_data;
                    tx_d.par = (^fifo_out_data[6:0]) ^ odd_sel;
                    tx_d.txd = 1'b0;
                end
            end
            shp_pkg::LINE_START: begin
                if (tx_bit_end) begin
                    tx_d.st = shp_pkg::LINE_DATA;
                    tx_d.bit_n = '0;
                    tx_d.txd = tx_q.sh[0];
                    tx_d.sh = {1'b0, tx_q.sh[7:1]};
                end
            end
            shp_pkg::LINE_DATA: begin
                if (tx_bit_end) begin
                    if (tx_q.bit_n != data_last) begin
                        tx_d.bit_n = 3'(tx_q.bit_n + 1'b1);
                        tx_d.txd = tx_q.sh[0];
                        tx_d.sh = {1'b0, tx_q.sh[7:1]};
                    end else if (parity_on) begin
                        tx_d.st = shp_pkg::LINE_PARITY;
                        tx_d.txd = tx_q.par;
                    end else begin
                        tx_d.st = shp_pkg::LINE_STOP;
                        tx_d.bit_n = '0;
                        tx_d.txd = 1'b1;
                    end
                end
            end
            shp_pkg::LINE_PARITY: begin
                if (tx_bit_end) begin
                    tx_d.st = shp_pkg::LINE_STOP;
                    tx_d.bit_n = '0;
                    tx_d.txd = 1'b1;
                end
            end
            shp_pkg::LINE_STOP: begin
                if (tx_bit_end) begin
                    if (tx_q.bit_n == `SHP_STOP_LAST) begin
                        tx_d.st = shp_pkg::LINE_IDLE;
                    end else begin
                        tx_d.bit_n = 3'(tx_q.bit_n + 1'b1);
                    end
                end
            end
            default: begin
                tx_d.st = shp_pkg::LINE_IDLE;
                tx_d.txd = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_q <= '{st: shp_pkg::LINE_IDLE, tick: 4'h0, bit_n: 3'h0, sh: 8'h00,
                      par: 1'b0, txd: 1'b1};
        end else begin
            tx_q <= tx_d;
        end
    end

    // ======================================================================
    // receiver: start checked at mid bit, then one sample per bit time
    assign rx_sample = tick && (rx_q.tick == `SHP_TICK_LAST);
    assign rx_char = parity_on ? {1'b0, rx_q.sh[7:1]} : rx_q.sh;

    always_comb begin
        rx_d = rx_q;
        err_set = '0;
        if (rd_rx) begin
            rx_d.full = 1'b0;
        end
        if (tick) begin
            rx_d.tick = 4'(rx_q.tick + 1'b1);
        end
        unique case (rx_q.st)
            shp_pkg::LINE_IDLE: begin
                if (tick && !rxd) begin
                    rx_d.st = shp_pkg::LINE_START;
                    rx_d.tick = '0;
                end
            end
            shp_pkg::LINE_START: begin
                if (tick && rx_q.tick == `SHP_TICK_MID) begin
                    rx_d.tick = '0;
                    rx_d.bit_n = '0;
                    // a short low pulse is a glitch, not a start
                    rx_d.st = rxd ? shp_pkg::LINE_IDLE : shp_pkg::LINE_DATA;
                end
            end
            shp_pkg::LINE_DATA: begin
                if (rx_sample) begin
                    rx_d.sh = {rxd, rx_q.sh[7:1]};
                    rx_d.bit_n = 3'(rx_q.bit_n + 1'b1);
                    if (rx_q.bit_n == data_last) begin
                        rx_d.bit_n = '0;
                        rx_d.st = parity_on ? shp_pkg::LINE_PARITY : shp_pkg::LINE_STOP;
                    end
                end
            end
            shp_pkg::LINE_PARITY: begin
                if (rx_sample) begin
                    err_set.parity = ((^rx_q.sh[7:1]) ^ rxd) != odd_sel;
                    rx_d.st = shp_pkg::LINE_STOP;
                end
            end
            shp_pkg::LINE_STOP: begin
                if (rx_sample) begin
                    err_set.frame = !rxd;
                    rx_d.bit_n = 3'(rx_q.bit_n + 1'b1);
                    if (rx_q.bit_n == `SHP_STOP_LAST) begin
                        rx_d.st = shp_pkg::LINE_IDLE;
                        rx_d.bit_n = '0;
                        if (rx_q.full && !rd_rx) begin
                            err_set.overrun = 1'b1;
                        end else begin
                            rx_d.hold = rx_char;
                            rx_d.full = 1'b1;
                        end
                    end
                end
            end
            default: begin
                rx_d.st = shp_pkg::LINE_IDLE;
            end
        endcase
        // terminal ready only while a character can be taken
        dtr_d = !rx_d.full;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_q <= '{st: shp_pkg::LINE_IDLE, tick: 4'h0, bit_n: 3'h0, sh: 8'h00,
                      hold: 8'h00, full: 1'b0};
            dtr_q <= 1'b0;
        end else begin
            rx_q <= rx_d;
            dtr_q <= dtr_d;
        end
    end

endmodule : shp_serial_host_port

//--- tb/shp_port_assertions.sv
// Purpose: port checks of the serial host port
// Assumes: rxd and dsr driven in step with pclk
// Notes: bound into every instance of the top module
`timescale 1ns/100ps
`include "shp_cfg.svh"
module shp_port_checker #(
    parameter int unsigned CLK_HZ = 40000000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rxd,
    input wire logic txd,
    input wire logic dsr,
    input wire logic dtr
);
    // ====================
    // helpers
    // one slowest frame plus a bit: a frame in flight when dsr fell is done by then
    localparam int FRAME_MAX = 12 * 16 * (CLK_HZ / 4800);
    int dsr_low_run;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dsr_low_run <= 0;
        end else if (dsr) begin
            dsr_low_run <= 0;
        end else if (dsr_low_run <= FRAME_MAX) begin
            dsr_low_run <= dsr_low_run + 1;
        end
    end
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ====================
    // assertions
    answer_setup_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    answer_once_a: assert property (pready |=> !pready)
        else $error("answer longer than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without answer");
    unmapped_err_a: assert property (psel && !penable && paddr > `SHP_ADDR_RXDATA
        |=> pslverr && (pwrite || prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    hold_no_dsr_a: assert property (dsr_low_run > FRAME_MAX |-> txd)
        else $error("frame sent without dsr");
    start_len_a: assert property ($fell(txd) |=> !txd [*8])
        else $error("low bit too short");
    stop_len_a: assert property ($rose(txd) |=> txd [*8])
        else $error("high bit too short");
    dtr_after_read_a: assert property (pready && !pwrite && paddr == `SHP_ADDR_RXDATA
        |-> ##[1:2] dtr)
        else $error("dtr not back after read");
    cover property ($fell(txd));
    cover property (pslverr);
    cover property ($fell(dtr));
endmodule : shp_port_checker

bind shp_serial_host_port shp_port_checker #(.CLK_HZ(CLK_HZ)) u_shp_port_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .dsr(dsr), .dtr(dtr));

//--- tb/shp_host_model.sv
// Purpose: host terminal on the far end of the serial line
// Assumes: bit_clks and fmt match the port setting
// Notes: samples mid bit; counts bad start or stop levels
`timescale 1ns/100ps
module shp_host_model (
    input wire logic pclk,
    input wire logic txd,
    input wire logic [1:0] fmt,
    input wire logic [15:0] bit_clks,
    output logic rxd,
    output logic dsr
);
    // ====================
    // receive side
    logic dsr_on;
    logic got_par;
    logic [7:0] d;
    logic [7:0] q_rx[$];
    int bad_frames;
    initial begin
        rxd = 1'b1;
        dsr_on = 1'b1;
        got_par = 1'b0;
        bad_frames = 0;
    end
    assign dsr = dsr_on;
    always begin
        @(negedge txd);
        d = 8'h00;
        repeat (bit_clks / 2) @(posedge pclk);
        if (txd !== 1'b0) bad_frames++;
        for (int i = 0; i < ((fmt == 2'h0) ? 8 : 7); i++) begin
            repeat (bit_clks) @(posedge pclk);
            d[i] = txd;
        end
        if (fmt != 2'h0) begin
            repeat (bit_clks) @(posedge pclk);
            got_par = txd;
        end
        repeat (2) begin
            repeat (bit_clks) @(posedge pclk);
            if (txd !== 1'b1) bad_frames++;
        end
        q_rx.push_back(d);
    end
    // ====================
    // send side, frame bits lsb first
    task automatic send_bits(input logic [10:0] b);
        for (int i = 0; i < 11; i++) begin
            @(posedge pclk);
            rxd <= b[i];
            repeat (bit_clks - 1) @(posedge pclk);
        end
        @(posedge pclk);
        rxd <= 1'b1;
    endtask : send_bits
endmodule : shp_host_model

//--- tb/shp_serial_host_port_tb.sv
// Purpose: self-checking bench of the serial host port
// Assumes: CLK_HZ lowered so 9600 baud is 16 clocks a bit
// Notes: register traffic over APB, line traffic via host model
`timescale 1ns/100ps
`include "shp_cfg.svh"
module shp_serial_host_port_tb;
    // ====================
    // signals and tasks
    localparam int unsigned CLK_HZ = 160000;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, dsr, dtr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] fmt;
    logic [15:0] bit_clks;
    logic [7:0] ex;
    int rates[6] = '{300, 600, 1200, 2400, 4800, 9600};
    int fail_count = 0;
    int n_checks = 0;
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    shp_serial_host_port #(.CLK_HZ(CLK_HZ)) u_shp_serial_host_port (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
        .txd(txd), .dsr(dsr), .dtr(dtr));
    shp_host_model u_shp_host_model (.pclk(pclk), .txd(txd), .fmt(fmt),
        .bit_clks(bit_clks), .rxd(rxd), .dsr(dsr));
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            fail_count++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_rx(input int k);
        int n;
        n = 0;
        while (u_shp_host_model.q_rx.size() < k && n < 8000) begin
            @(posedge pclk);
            n++;
        end
        if (u_shp_host_model.q_rx.size() < k) begin
            fail_count++;
            complete_run();
        end
        repeat (bit_clks) @(posedge pclk);
    endtask : wait_rx
    task automatic rx_frame(input logic stop2, input logic [7:0] ch, input logic [31:0] st);
        u_shp_host_model.send_bits({stop2, 1'b1, ch, 1'b0});
        repeat (4) @(posedge pclk);
        apb(1'b0, `SHP_ADDR_STATUS, 32'h0000_0000);
        check(rd, st);
    endtask : rx_frame
    // ====================
    // sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        fmt = 2'h0;
        bit_clks = 16'h0010;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `SHP_ADDR_CTRL, 32'h0000_0000);
        check(rd, 32'h0000_0005);
        apb(1'b0, `SHP_ADDR_STATUS, 32'h0000_0000);
        check(rd, 32'h0000_00D0);
        apb(1'b0, 12'h010, 32'h0000_0000);
        check({31'h0000_0000, er}, 32'h0000_0001);
        apb(1'b1, `SHP_ADDR_CTRL, 32'h0000_0006);
        apb(1'b0, `SHP_ADDR_CTRL, 32'h0000_0000);
        check(rd, 32'h0000_0005);
        // every rate once, formats in turn
        for (int s = 0; s < 6; s++) begin
            apb(1'b1, `SHP_ADDR_CTRL, 32'((s % 3) * 8 + s));
            fmt <= 2'(s % 3);
            bit_clks <= 16'(16 * (CLK_HZ / (16 * rates[s])));
            apb(1'b1, `SHP_ADDR_TXDATA, 32'h0000_00A5);
            wait_rx(1);
            ex = (fmt == 2'h0) ? 8'hA5 : 8'h25;
            check(u_shp_host_model.q_rx.pop_front(), ex);
            if (fmt != 2'h0) check(u_shp_host_model.got_par, (fmt == 2'h1) ? ^ex : ~^ex);
        end
        check(u_shp_host_model.bad_frames, 0);
        // fifo fills while the host holds off
        apb(1'b1, `SHP_ADDR_CTRL, 32'h0000_0005);
        fmt <= 2'h0;
        u_shp_host_model.dsr_on <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, `SHP_ADDR_TXDATA, 32'(8'h11 << (i % 4)));
            check({31'h0000_0000, er}, (i == 4) ? 32'h0000_0001 : 32'h0000_0000);
        end
        apb(1'b0, `SHP_ADDR_STATUS, 32'h0000_0000);
        check(rd, 32'h0000_04A0);
        repeat (6400) @(posedge pclk);
        check({31'h0000_0000, txd}, 32'h0000_0001);
        u_shp_host_model.dsr_on <= 1'b1;
        wait_rx(4);
        for (int i = 0; i < 4; i++) check(u_shp_host_model.q_rx.pop_front(), 8'h11 << i);
        // receive, overrun, frame error
        rx_frame(1'b1, 8'h3C, 32'h0000_0051);
        rx_frame(1'b1, 8'h5A, 32'h0000_0059);
        apb(1'b0, `SHP_ADDR_RXDATA, 32'h0000_0000);
        check(rd, 32'h0000_003C);
        apb(1'b1, `SHP_ADDR_STATUS, 32'h0000_0008);
        check({31'h0000_0000, dtr}, 32'h0000_0001);
        rx_frame(1'b0, 8'h5A, 32'h0000_0055);
        apb(1'b0, `SHP_ADDR_RXDATA, 32'h0000_0000);
        check(rd, 32'h0000_005A);
        // even/7 with a wrong parity bit; frame error still sticky
        apb(1'b1, `SHP_ADDR_CTRL, 32'h0000_000D);
        rx_frame(1'b1, 8'hDA, 32'h0000_0057);
        apb(1'b0, `SHP_ADDR_RXDATA, 32'h0000_0000);
        check(rd, 32'h0000_005A);
        complete_run();
    end
endmodule : shp_serial_host_port_tb
